// ### rtl/imc_pkg.sv
package imc_pkg;
   localparam logic [31:0] MODE_HI_OFS = 32'hffffe01c;
   localparam logic [31:0] MODE_OFS = 32'hffffe020;
   localparam logic [31:0] STAT_OFS = 32'hffffe0f0;
   localparam logic [31:0] MASK_OFS = 32'hffffe0f4;
   localparam int LVL_LSB = 0;
   localparam int LVL_MSB = 2;
   localparam int DMA_BIT = 4;
   localparam int MODE_LSB = 5;
   localparam int MODE_MSB = 6;
   localparam logic [7:0] BYTE_WMASK = 8'h77;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [1:0] MODE_RISE = 2'h3;
   localparam int STAT_SRC31 = 0;
   localparam int STAT_SRC32 = 1;
   localparam logic [1:0] STAT_RST = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam logic [2:0] LVL_OFF = 3'h0;
   typedef enum logic [1:0] {
      DET_LEVEL = 2'h1,
      DET_RISE = 2'h2
   } det_kind_t;
endpackage

// ### rtl/imc_slice.sv
`timescale 1ns/1ns
module imc_slice (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [31:0] busAddr,
   input wire logic [31:0] busWrData,
   input wire logic busWrEn,
   input wire logic busRdEn,
   output logic [31:0] busRdData,
   input wire logic compare2Irq,
   input wire logic compare3Irq,
   output logic intReq31,
   output logic [2:0] intLevel31,
   output logic dmaReq31,
   output logic [2:0] dmaChan31,
   output logic intReq32,
   output logic [2:0] intLevel32,
   output logic dmaReq32,
   output logic [2:0] dmaChan32,
   output logic irqOut
);
   function automatic logic [7:0] maskByte(input logic [7:0] d);
      return d & imc_pkg::BYTE_WMASK;
   endfunction

   // {interrupt request, dma request} for one source byte
   function automatic logic [1:0] route(input logic det,
                                         input logic [7:0] b);
      logic sel;
      logic [2:0] lvl;
      sel = b[imc_pkg::DMA_BIT];
      lvl = b[imc_pkg::LVL_MSB:imc_pkg::LVL_LSB];
      return {det & ~sel & (lvl != imc_pkg::LVL_OFF), det & sel};
   endfunction

   logic [7:0] src31Byte_r;
   logic [7:0] src32Byte_r;
   logic [7:0] src33Byte_r;
   logic [1:0] stat_r;
   logic [1:0] stat_nxt;
   logic [1:0] mask_r;
   logic [1:0] mask_nxt;
   logic [31:0] rdData_r;
   logic irq_r;
   logic intReq31_r;
   logic dmaReq31_r;
   logic intReq32_r;
   logic dmaReq32_r;
   logic [2:0] intLevel31_r;
   logic [2:0] dmaChan31_r;
   logic [2:0] intLevel32_r;
   logic [2:0] dmaChan32_r;

   logic det31;
   logic det32;
   logic hitHi;
   logic hitMode;
   logic hitStat;
   logic hitMask;
   logic [31:0] rdSel;
   logic dmaSel31;
   logic dmaSel32;
   logic [2:0] lvl31;
   logic [2:0] lvl32;
   logic [1:0] route31;
   logic [1:0] route32;
   logic [1:0] events;
   logic statClr;

   req_detect u_det31 (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .mode(src31Byte_r[imc_pkg::MODE_MSB:imc_pkg::MODE_LSB]),
      .src(compare2Irq),
      .det(det31)
   );

   req_detect u_det32 (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .mode(src32Byte_r[imc_pkg::MODE_MSB:imc_pkg::MODE_LSB]),
      .src(compare3Irq),
      .det(det32)
   );

   assign hitHi = busAddr == imc_pkg::MODE_HI_OFS;
   assign hitMode = busAddr == imc_pkg::MODE_OFS;
   assign hitStat = busAddr == imc_pkg::STAT_OFS;
   assign hitMask = busAddr == imc_pkg::MASK_OFS;

   assign dmaSel31 = src31Byte_r[imc_pkg::DMA_BIT];
   assign dmaSel32 = src32Byte_r[imc_pkg::DMA_BIT];
   assign lvl31 = src31Byte_r[imc_pkg::LVL_MSB:imc_pkg::LVL_LSB];
   assign lvl32 = src32Byte_r[imc_pkg::LVL_MSB:imc_pkg::LVL_LSB];
   assign route31 = route(det31, src31Byte_r);
   assign route32 = route(det32, src32Byte_r);

   // reserved bits held zero by the write mask
   assign rdSel = hitHi ? {src31Byte_r, 24'h000000} :
                  hitMode ? {16'h0000, src33Byte_r, src32Byte_r} :
                  hitStat ? {30'h0, stat_r} :
                  hitMask ? {30'h0, mask_r} : 32'h00000000;

   assign events = {det32, det31};
   assign statClr = busRdEn & hitStat;
   // a new event beats the read clear
   assign stat_nxt = (stat_r & ~{2{statClr}}) | events;
   assign mask_nxt = (busWrEn & hitMask) ? busWrData[1:0] : mask_r;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         src31Byte_r <= imc_pkg::BYTE_RST;
         src32Byte_r <= imc_pkg::BYTE_RST;
         src33Byte_r <= imc_pkg::BYTE_RST;
      end else if (busWrEn && hitHi) begin
         src31Byte_r <= maskByte(busWrData[31:24]);
      end else if (busWrEn && hitMode) begin
         src32Byte_r <= maskByte(busWrData[7:0]);
         src33Byte_r <= maskByte(busWrData[15:8]);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         stat_r <= imc_pkg::STAT_RST;
         mask_r <= imc_pkg::MASK_RST;
         irq_r <= 1'b0;
         rdData_r <= 32'h00000000;
      end else begin
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq_r <= |(stat_nxt & mask_nxt);
         rdData_r <= busRdEn ? rdSel : 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         intReq31_r <= 1'b0;
         dmaReq31_r <= 1'b0;
         intReq32_r <= 1'b0;
         dmaReq32_r <= 1'b0;
      end else begin
         intReq31_r <= route31[1];
         dmaReq31_r <= route31[0];
         intReq32_r <= route32[1];
         dmaReq32_r <= route32[0];
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         intLevel31_r <= imc_pkg::LVL_OFF;
         dmaChan31_r <= imc_pkg::LVL_OFF;
         intLevel32_r <= imc_pkg::LVL_OFF;
         dmaChan32_r <= imc_pkg::LVL_OFF;
      end else begin
         intLevel31_r <= dmaSel31 ? imc_pkg::LVL_OFF : lvl31;
         dmaChan31_r <= dmaSel31 ? lvl31 : imc_pkg::LVL_OFF;
         intLevel32_r <= dmaSel32 ? imc_pkg::LVL_OFF : lvl32;
         dmaChan32_r <= dmaSel32 ? lvl32 : imc_pkg::LVL_OFF;
      end
   end

   assign busRdData = rdData_r;
   assign irqOut = irq_r;
   assign intReq31 = intReq31_r;
   assign dmaReq31 = dmaReq31_r;
   assign intReq32 = intReq32_r;
   assign dmaReq32 = dmaReq32_r;
   assign intLevel31 = intLevel31_r;
   assign dmaChan31 = dmaChan31_r;
   assign intLevel32 = intLevel32_r;
   assign dmaChan32 = dmaChan32_r;

   property p_dma31;
      @(posedge clk_sys) disable iff (sys_rst)
         (det31 && dmaSel31) |=> dmaReq31 && !intReq31;
   endproperty
   a_dma31: assert property (p_dma31)
      else $error("source 31 dma trigger missing");

   property p_nodma31;
      @(posedge clk_sys) disable iff (sys_rst)
         !dmaSel31 |=> !dmaReq31;
   endproperty
   a_nodma31: assert property (p_nodma31)
      else $error("source 31 dma trigger while deselected");

   property p_dma32;
      @(posedge clk_sys) disable iff (sys_rst)
         (det32 && dmaSel32) |=> dmaReq32 ##1 (dmaReq32 || !$past(det32));
   endproperty
   a_dma32: assert property (p_dma32)
      else $error("source 32 dma trigger wrong");

   property p_lvl31;
      @(posedge clk_sys) disable iff (sys_rst)
         (det31 && !dmaSel31 && lvl31 != 3'h0)
            |=> intReq31 && intLevel31 == $past(lvl31);
   endproperty
   a_lvl31: assert property (p_lvl31)
      else $error("source 31 level request wrong");

   property p_off31;
      @(posedge clk_sys) disable iff (sys_rst)
         (lvl31 == 3'h0) |=> !intReq31;
   endproperty
   a_off31: assert property (p_off31)
      else $error("source 31 requested while disabled");

   property p_chan;
      @(posedge clk_sys) disable iff (sys_rst)
         dmaSel31 |=> dmaChan31 == $past(lvl31) && intLevel31 == 3'h0;
   endproperty
   a_chan: assert property (p_chan)
      else $error("source 31 channel wrong");

   property p_off32;
      @(posedge clk_sys) disable iff (sys_rst)
         (lvl32 == 3'h0 || dmaSel32) |=> !intReq32;
   endproperty
   a_off32: assert property (p_off32)
      else $error("source 32 requested while disabled");

   property p_rsvd;
      @(posedge clk_sys) disable iff (sys_rst)
         (busRdEn && hitHi) |=> busRdData[27] == 1'b0
            && busRdData[31] == 1'b0 && busRdData[23:0] == 24'h000000;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bits read nonzero");

   property p_rise;
      @(posedge clk_sys) disable iff (sys_rst)
         (src31Byte_r[imc_pkg::MODE_MSB:imc_pkg::MODE_LSB]
            == imc_pkg::MODE_RISE && $stable(src31Byte_r)
            && compare2Irq && $past(compare2Irq)) |=> !det31;
   endproperty
   a_rise: assert property (p_rise)
      else $error("rising mode detected a held level");

   property p_sticky;
      @(posedge clk_sys) disable iff (sys_rst)
         det31 |=> stat_r[0] ##0 (irqOut == mask_r[0] || stat_r[1]);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("status bit lost an event");

   c_dma31: cover property (@(posedge clk_sys) disable iff (sys_rst)
      dmaReq31 && dmaChan31 == 3'h7);
   c_int32: cover property (@(posedge clk_sys) disable iff (sys_rst)
      intReq32 && intLevel32 == 3'h7);
   c_irq: cover property (@(posedge clk_sys) disable iff (sys_rst)
      statClr && |events ##1 irqOut);
endmodule

// ### rtl/req_detect.sv
`timescale 1ns/1ns
module req_detect (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [1:0] mode,
   input wire logic src,
   output logic det
);
   logic prev_r;
   logic det_r;
   logic det_nxt;
   imc_pkg::det_kind_t kind;

   assign kind = (mode == imc_pkg::MODE_RISE) ? imc_pkg::DET_RISE
                                             : imc_pkg::DET_LEVEL;

   always_comb begin
      unique case (kind)
         imc_pkg::DET_RISE: det_nxt = src & ~prev_r;
         imc_pkg::DET_LEVEL: det_nxt = src;
         default: det_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r <= 1'b0;
         det_r <= 1'b0;
      end else begin
         prev_r <= src;
         det_r <= det_nxt;
      end
   end

   assign det = det_r;
endmodule

// ### verification/cmp_source.sv
`timescale 1ns/1ns
module cmp_source (
   input wire logic clk_sys,
   input wire logic go31,
   input wire logic go32,
   output logic compare2Irq,
   output logic compare3Irq
);
   // compare units hold their request as a registered level
   always_ff @(posedge clk_sys) begin
      compare2Irq <= go31;
      compare3Irq <= go32;
   end
endmodule

// ### verification/interrupt_mode_control_slice_tb_top.sv
`timescale 1ns/1ns
module interrupt_mode_control_slice_tb_top;
   localparam logic [31:0] HI = imc_pkg::MODE_HI_OFS;
   localparam logic [31:0] LO = imc_pkg::MODE_OFS;
   localparam logic [31:0] ST = imc_pkg::STAT_OFS;
   localparam logic [31:0] MK = imc_pkg::MASK_OFS;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] busAddr = '0;
   logic [31:0] busWrData = '0;
   logic busWrEn = 1'b0;
   logic busRdEn = 1'b0;
   logic go31 = 1'b0;
   logic go32 = 1'b0;
   logic [31:0] busRdData, d;
   logic compare2Irq, compare3Irq, irqOut;
   logic intReq31, dmaReq31, intReq32, dmaReq32;
   logic [2:0] intLevel31, dmaChan31, intLevel32, dmaChan32;
   logic [15:0] o;
   int badCount = 0;
   int comparisons = 0;
   wire [3:0] reqs = {intReq31, dmaReq31, intReq32, dmaReq32};
   always #20 clk_sys = ~clk_sys;
   cmp_source i_src (.clk_sys(clk_sys), .go31(go31), .go32(go32),
      .compare2Irq(compare2Irq), .compare3Irq(compare3Irq));
   imc_slice i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .busAddr(busAddr), .busWrData(busWrData), .busWrEn(busWrEn),
      .busRdEn(busRdEn), .busRdData(busRdData),
      .compare2Irq(compare2Irq), .compare3Irq(compare3Irq),
      .intReq31(intReq31), .intLevel31(intLevel31), .dmaReq31(dmaReq31),
      .dmaChan31(dmaChan31), .intReq32(intReq32), .intLevel32(intLevel32),
      .dmaReq32(dmaReq32), .dmaChan32(dmaChan32), .irqOut(irqOut));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         badCount++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      busAddr <= a;
      busWrData <= v;
      busWrEn <= 1'b1;
      @(posedge clk_sys);
      busWrEn <= 1'b0;
   endtask
   task rd(input logic [31:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      busAddr <= a;
      busRdEn <= 1'b1;
      @(posedge clk_sys);
      busRdEn <= 1'b0;
      #1 v = busRdData;
   endtask
   // raise requests, poll a bounded time for any request output
   task fire(input logic s31, input logic s32, output logic [15:0] r);
      @(posedge clk_sys);
      go31 <= s31;
      go32 <= s32;
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         #1 r = {reqs, intLevel31, dmaChan31, intLevel32, dmaChan32};
         if (|reqs) break;
      end
   endtask
   task quiet;
      @(posedge clk_sys);
      go31 <= 1'b0;
      go32 <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   task t_regs;
      rd(HI, d); chk(d, 32'h0);
      rd(LO, d); chk(d, 32'h0);
      rd(ST, d); chk(d, 32'h0);
      rd(MK, d); chk(d, 32'h0);
      rd(32'hffffe000, d); chk(d, 32'h0);
      wr(HI, 32'hffffffff);
      rd(HI, d); chk(d, 32'h77000000);
      @(posedge clk_sys);
      #1 chk(busRdData, 32'h0);
      wr(LO, 32'hffffffff);
      rd(LO, d); chk(d, 32'h00007777);
      wr(LO, 32'h0);
   endtask
   task t_src31;
      logic [15:0] e;
      for (int v = 0; v < 16; v++) begin
         // odd codes use rising-edge detection, select bit at 28
         wr(HI, {1'b0, {2{v[0]}}, 1'(v >> 3), 1'b0, 3'(v), 24'h0});
         if (v >= 8) e = 16'h4000 | 16'(v % 8) << 6;
         else if (v == 0) e = 16'h0;
         else e = 16'h8000 | 16'(v) << 9;
         fire(1'b1, 1'b0, o);
         chk(32'(o), 32'(e));
         quiet;
      end
   endtask
   task t_src32;
      wr(HI, 32'h0);
      wr(LO, 32'h00000067);
      fire(1'b0, 1'b1, o);
      chk(32'(o), 32'h2038);
      @(posedge clk_sys);
      #1 chk(32'(intReq32), 32'h0);
      quiet;
      wr(LO, 32'h00000033);
      fire(1'b0, 1'b1, o);
      chk(32'(o), 32'h1003);
      @(posedge clk_sys);
      #1 chk(32'(dmaReq32), 32'h1);
      quiet;
   endtask
   task t_irq;
      rd(ST, d);
      wr(MK, 32'h1);
      wr(HI, 32'h01000000);
      fire(1'b1, 1'b0, o);
      quiet;
      chk(32'(irqOut), 32'h1);
      rd(ST, d); chk(d, 32'h1);
      repeat (2) @(posedge clk_sys);
      #1 chk(32'(irqOut), 32'h0);
      wr(MK, 32'h0);
      fire(1'b0, 1'b1, o);
      quiet;
      chk(32'(irqOut), 32'h0);
      rd(ST, d); chk(d, 32'h2);
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_regs;
      t_src31;
      t_src32;
      t_irq;
      test_done;
   end
   initial begin
      #(40 * 4000);
      badCount++;
      test_done;
   end
endmodule
